// ===== hdl/lane_err_counter.v
`default_nettype none

module lane_err_counter (
    // clock and reset
    input wire clk,
    input wire arst_n,
    input wire ce,
    // control
    input wire inc,
    input wire clr,
    input wire [7:0] threshold,
    // status
    output reg [7:0] count_reg,
    output wire at_threshold
);

    // =========================================
    // saturating error count
    reg [7:0] count_next;

    always @* begin
        count_next = count_reg;
        if (clr) begin
            count_next = 8'h00;
        end else if (inc && (count_reg != 8'hff)) begin
            count_next = count_reg + 8'h01;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_reg <= 8'h00;
        end else if (ce) begin
            count_reg <= count_next;
        end
    end

    assign at_threshold = (count_reg >= threshold);

endmodule // lane_err_counter

`default_nettype wire

// ===== hdl/lane_status_consts.vh
`ifndef LANE_STATUS_CONSTS_VH
`define LANE_STATUS_CONSTS_VH

// register offsets
`define OFS_LINK_PAGE 12'h300
`define OFS_UNEXP_CTRL_STATUS 12'h46f
`define OFS_CODEGROUP_LOCK 12'h470
`define OFS_ERR_THRESHOLD 12'h478
`define OFS_COUNT_CLEAR 12'h479
`define OFS_IRQ_STATUS 12'h47a
`define OFS_IRQ_MASK 12'h47b

// field positions
`define LINK_PAGE_BIT 0
`define IRQ_UEC_LINK0 0
`define IRQ_UEC_LINK1 1
`define IRQ_LOCK_LOST_LINK0 2
`define IRQ_LOCK_LOST_LINK1 3

// widths and reset values
`define NUM_LANES 8
`define NUM_LINKS 2
`define CNT_W 8
`define IRQ_W 4
`define ERR_THRESHOLD_RST 8'h01
`define LINK_PAGE_RST 1'b0
`define IRQ_MASK_RST 4'h0
`define CNT_MAX 8'hff

`endif

// ===== hdl/serial_link_lane_status.v
`include "lane_status_consts.vh"
`default_nettype none

module serial_link_lane_status (
    // clock and reset
    input wire clk,
    input wire arst_n,
    input wire ce,
    // receive lane events, link 1 in upper byte
    input wire [15:0] unexp_ctrl_char,
    input wire [15:0] codegroup_lock,
    // register port
    input wire [11:0] addr,
    input wire [7:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [7:0] rdata,
    // interrupt
    output wire irq
);

    // =========================================
    // software registers
    reg link_page_reg;
    reg [7:0] threshold_reg;
    reg [3:0] irq_status_reg;
    reg [3:0] irq_mask_reg;
    reg [7:0] lock_reg0;
    reg [7:0] lock_reg1;
    reg [1:0] uec_any_reg;
    reg [1:0] lock_all_reg;
    reg [7:0] rdata_next;
    reg [3:0] irq_status_next;

    wire wr_page = wr_en && (addr == `OFS_LINK_PAGE);
    wire wr_thresh = wr_en && (addr == `OFS_ERR_THRESHOLD);
    wire wr_clear = wr_en && (addr == `OFS_COUNT_CLEAR);
    wire wr_istat = wr_en && (addr == `OFS_IRQ_STATUS);
    wire wr_imask = wr_en && (addr == `OFS_IRQ_MASK);

    // =========================================
    // per-lane error counters
    wire [15:0] uec_flag;
    wire [15:0] cnt_clr;
    genvar g;

    // a clear write hits only the lanes of the paged link
    assign cnt_clr[7:0] = (wr_clear && !link_page_reg) ? wdata : 8'h00;
    assign cnt_clr[15:8] = (wr_clear && link_page_reg) ? wdata : 8'h00;

    generate
        for (g = 0; g < 16; g = g + 1) begin : lane_cnt
            lane_err_counter u_cnt (
                .clk(clk),
                .arst_n(arst_n),
                .ce(ce),
                .inc(unexp_ctrl_char[g]),
                .clr(cnt_clr[g]),
                .threshold(threshold_reg),
                .count_reg(),
                .at_threshold(uec_flag[g])
            );
        end
    endgenerate

    // =========================================
    // control and lock state
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            link_page_reg <= `LINK_PAGE_RST;
            threshold_reg <= `ERR_THRESHOLD_RST;
            irq_mask_reg <= `IRQ_MASK_RST;
            irq_status_reg <= 4'h0;
            lock_reg0 <= 8'h00;
            lock_reg1 <= 8'h00;
            uec_any_reg <= 2'b00;
            lock_all_reg <= 2'b00;
            rdata <= 8'h00;
        end else if (ce) begin
            if (wr_page) begin
                link_page_reg <= wdata[`LINK_PAGE_BIT];
            end
            if (wr_thresh) begin
                threshold_reg <= wdata;
            end
            if (wr_imask) begin
                irq_mask_reg <= wdata[3:0];
            end
            irq_status_reg <= irq_status_next;
            lock_reg0 <= codegroup_lock[7:0];
            lock_reg1 <= codegroup_lock[15:8];
            uec_any_reg <= {|uec_flag[15:8], |uec_flag[7:0]};
            lock_all_reg <= {&lock_reg1, &lock_reg0};
            rdata <= rdata_next;
        end
    end

    // =========================================
    // interrupt events, set beats write-one clear
    reg [3:0] irq_event;

    always @* begin
        irq_event = 4'h0;
        irq_event[`IRQ_UEC_LINK0] = (|uec_flag[7:0]) && !uec_any_reg[0];
        irq_event[`IRQ_UEC_LINK1] = (|uec_flag[15:8]) && !uec_any_reg[1];
        irq_event[`IRQ_LOCK_LOST_LINK0] = lock_all_reg[0] && !(&lock_reg0);
        irq_event[`IRQ_LOCK_LOST_LINK1] = lock_all_reg[1] && !(&lock_reg1);
        irq_status_next = irq_status_reg;
        if (wr_istat) begin
            irq_status_next = irq_status_reg & ~wdata[3:0];
        end
        irq_status_next = irq_status_next | irq_event;
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // =========================================
    // read decode, data in the cycle after the strobe
    always @* begin
        rdata_next = 8'h00;
        if (rd_en) begin
            case (addr)
                `OFS_LINK_PAGE: rdata_next = {7'h00, link_page_reg};
                `OFS_UNEXP_CTRL_STATUS: begin
                    // lane n at bit n of the paged link
                    rdata_next = link_page_reg ? uec_flag[15:8] : uec_flag[7:0];
                end
                `OFS_CODEGROUP_LOCK: begin
                    // all eight lanes, bits 7 down to 0
                    rdata_next = link_page_reg ? lock_reg1 : lock_reg0;
                end
                `OFS_ERR_THRESHOLD: rdata_next = threshold_reg;
                `OFS_IRQ_STATUS: rdata_next = {4'h0, irq_status_reg};
                `OFS_IRQ_MASK: rdata_next = {4'h0, irq_mask_reg};
                default: rdata_next = 8'h00;
            endcase
        end
    end

endmodule // serial_link_lane_status

`default_nettype wire

// ===== testbench/lane_src_model.sv
`default_nettype none
module lane_src_model (
    input wire logic clk,
    input wire logic [15:0] err_req,
    input wire logic [15:0] lock_req,
    output logic [15:0] unexp_ctrl_char = '0,
    output logic [15:0] codegroup_lock = '0
);
    timeunit 1ns;
    timeprecision 1ps;
    // error pulses and lock levels, one cycle after the request
    always @(posedge clk) begin
        unexp_ctrl_char <= err_req;
        codegroup_lock <= lock_req;
    end
endmodule // lane_src_model
`default_nettype wire

// ===== testbench/lane_status_monitor.sv
`default_nettype none
module lane_status_monitor (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic [15:0] unexp_ctrl_char,
    input wire logic [15:0] codegroup_lock,
    input wire logic [11:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic pg_reg;
    always @(posedge clk or negedge arst_n)
        if (!arst_n) pg_reg <= 1'b0;
        else if (ce && wr_en && addr == 12'h300) pg_reg <= wdata[0];
    sequence thr_zero;
        ce && wr_en && addr == 12'h478 && wdata == 8'h00;
    endsequence
    sequence rd_flags;
        ce && rd_en && addr == 12'h46f;
    endsequence
    sequence rd_page;
        ce && rd_en && addr == 12'h300;
    endsequence
    idle_zero_a: assert property (ce && !rd_en |=> rdata == 8'h00)
        else $error("rdata not zero");
    lock_read_a: assert property (ce && rd_en && addr == 12'h470 && $stable(codegroup_lock)
        |=> rdata == (pg_reg ? $past(codegroup_lock[15:8]) : $past(codegroup_lock[7:0])))
        else $error("lock flags wrong");
    thr_zero_a: assert property (thr_zero ##[1:3] rd_flags |=> rdata == 8'hff)
        else $error("zero threshold flags wrong");
    mask_off_a: assert property (ce && wr_en && addr == 12'h47b && wdata == 8'h00 |=> !irq)
        else $error("irq with mask clear");
    page_read_a: assert property (rd_page |=> rdata == {7'h00, pg_reg})
        else $error("page readback wrong");
    unmapped_zero_a: assert property (ce && rd_en && addr == 12'h123 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule // lane_status_monitor
bind serial_link_lane_status lane_status_monitor u_lane_status_monitor (.*);
`default_nettype wire

// ===== testbench/serial_link_lane_status_test.sv
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %s exp %h got %h", n, e, g); end end
module serial_link_lane_status_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, arst_n = 0, wr_en = 0, rd_en = 0;
    logic [11:0] addr = '0;
    logic [7:0] wdata = '0, m;
    logic [15:0] err_req = '0, lock_req = '0, uec, lock;
    logic [31:0] lf = 32'h0ea5;
    wire logic irq;
    wire logic [7:0] rdata;
    int errors = 0, cmp_count = 0, cyc = 0;
    always #4 clk = ~clk;
    lane_src_model u_lane_src_model (.clk(clk), .err_req(err_req), .lock_req(lock_req),
        .unexp_ctrl_char(uec), .codegroup_lock(lock));
    serial_link_lane_status u_serial_link_lane_status (.clk(clk), .arst_n(arst_n),
        .ce(1'b1), .unexp_ctrl_char(uec), .codegroup_lock(lock), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] pick(input logic [15:0] v, input logic p);
        return p ? v[15:8] : v[7:0];
    endfunction
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 `CHK("rdata", e, rdata)
    endtask
    task automatic pulse(input logic [15:0] v);
        @(posedge clk);
        err_req <= v;
        @(posedge clk);
        err_req <= '0;
    endtask
    task automatic close_out;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            close_out();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        rd(12'h46f, 8'h00);
        rd(12'h470, 8'h00);
        for (int i = 0; i < 8; i++) begin
            lf = nxt(lf);
            @(posedge clk);
            lock_req <= lf[15:0];
            for (int p = 0; p < 2; p++) begin
                wr(12'h300, 8'(p));
                rd(12'h300, 8'(p));
                rd(12'h470, pick(lf[15:0], p[0]));
            end
        end
        $display("lock test done");
        wr(12'h478, 8'h03);
        for (int p = 0; p < 2; p++) begin
            lf = nxt(lf);
            m = lf[7:0];
            wr(12'h300, 8'(p));
            wr(12'h479, 8'hff);
            repeat (2) pulse({m, m} & (p ? 16'hff00 : 16'h00ff));
            rd(12'h46f, 8'h00);
            pulse({m, m} & (p ? 16'hff00 : 16'h00ff));
            rd(12'h46f, m);
            wr(12'h46f, ~m);
            rd(12'h46f, m);
        end
        wr(12'h478, 8'h00);
        rd(12'h46f, 8'hff);
        rd(12'h123, 8'h00);
        $display("error flag test done");
        wr(12'h47b, 8'h0f);
        #1 `CHK("irq", 1'b1, irq)
        wr(12'h47a, 8'h0f);
        #1 `CHK("irq", 1'b0, irq)
        wr(12'h47b, 8'h00);
        $display("irq test done");
        close_out();
    end
endmodule // serial_link_lane_status_test
`default_nettype wire
